// ===== src/srcfg_map.vh
// register map constants for the safety response configuration bank
// assumes an spi frame decoder supplies register index and write data
`ifndef SRCFG_MAP_VH
`define SRCFG_MAP_VH

// ----------------------------------------------------------------------
// register indices (chosen, no offset printed)
// ----------------------------------------------------------------------
`define SRCFG_IDX_FAULT_RESP   2'h0
`define SRCFG_IDX_FEATURE      2'h1
`define SRCFG_IDX_THRESH       2'h2

// ----------------------------------------------------------------------
// fault response register fields
// ----------------------------------------------------------------------
`define SRCFG_CLK_WARN_BIT     7
`define SRCFG_SCHED_EN_BIT     5
`define SRCFG_AUTO_DIS_BIT     4
`define SRCFG_ANALOG_SELFTEST_FAIL_BIT   3
`define SRCFG_ENOUT_ERR_BIT    2
`define SRCFG_RSTDRV_RST_BIT   1
`define SRCFG_RSTDRV_SAFE_BIT  0
`define SRCFG_FAULT_RESP_MASK  8'hbf
`define SRCFG_FAULT_RESP_RST   8'h00

// ----------------------------------------------------------------------
// feature register fields
// ----------------------------------------------------------------------
`define SRCFG_SSM_BIT          6
`define SRCFG_CRC_BIT          4
`define SRCFG_WATCHDOG_CONFIG_BIT_BIT       3
`define SRCFG_ESM_MODE_BIT     2
`define SRCFG_WD_RST_BIT       1
`define SRCFG_ESM_RST_BIT      0
`define SRCFG_FEATURE_MASK     8'h5f
`define SRCFG_FEATURE_RST      8'h02
`define SRCFG_FEATURE_RSTMASK  8'h07

// ----------------------------------------------------------------------
// thresholds: [7:4] mcu error reset, [3:0] watchdog reset
// ----------------------------------------------------------------------
`define SRCFG_THRESH_RST       8'hff

// ----------------------------------------------------------------------
// operating states
// ----------------------------------------------------------------------
`define SRCFG_ST_RESET         3'h0
`define SRCFG_ST_DIAG          3'h1
`define SRCFG_ST_ACTIVE        3'h2
`define SRCFG_ST_SAFE          3'h3

`endif

// ===== src/srcfg_reg8.v
// one 8-bit configuration register with write mask and reload value
// assumes write strobe already qualified by state and lock
`timescale 1ns/1ps
module srcfg_reg8 #(
  parameter [7:0] WMASK   = 8'hff,
  parameter [7:0] RSTVAL  = 8'h00,
  parameter [7:0] RELMASK = 8'h00
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rstn_i,
  // control
  input  wire       we_i,
  input  wire       reload_i,
  input  wire [7:0] wdata_i,
  // value
  output reg  [7:0] q_o
);

  // reload outranks a write in the same cycle: entering reset wins
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o <= RSTVAL;
    end else if (reload_i) begin
      q_o <= (q_o & ~RELMASK) | (RSTVAL & RELMASK);
    end else if (we_i) begin
      q_o <= wdata_i & WMASK;
    end
  end

endmodule

// ===== src/srcfg_sync2.v
// two flip-flop synchroniser for an asynchronous level
// assumes a single clock domain on the receiving side
`timescale 1ns/1ps
module srcfg_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rstn_i,
  // data
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ===== src/srcfg_top.v
// safety response configuration bank and its fault decision logic
// assumes an spi decoder gives index, data and strobes on clk_i, and
// that fault pins and counters arrive asynchronously from the analog side
`timescale 1ns/1ps
`include "srcfg_map.vh"

// Summary of operation
// [R1] clock warning forces safe from diagnostic or active when enabled
// [R2] self-test scheduler runs in active, enabled, with a group start set
// [R3] auto self-test runs on reset entry unless disabled
// [R4] analog self-test failure forces safe when enabled
// [R5] enable output driver fault forces safe when enabled
// [R6] reset driver fault forces reset when reset response enabled
// [R7] reset driver fault forces safe when safe response enabled
// [R8] reset response wins over safe response for reset driver fault
// [R9] spread spectrum enable bit drives modulation on or off
// [R10] crc enable bit turns spi frame crc protection on or off
// [R11] mode bit selects low-level or pwm mcu error monitoring
// [R12] watchdog threshold gives reset when enable set, else safe
// [R13] in safe the watchdog reset enable is masked, not cleared
// [R14] mcu error threshold gives reset when enable set, else safe
// [R15] three feature bits return to defaults on every reset entry
// [R16] writes accepted only in diagnostic with lock clear
// [R17] watchdog threshold default fifteen; reaching it sets failure flag
// [R18] mcu error threshold default fifteen, acts in active, diag, safe
// [R19] reserved bits read zero and ignore writes
module srcfg_top (
  // clock and reset
  input  wire       clk_i,
  input  wire       rstn_i,
  // register access from spi decoder
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [1:0] idx_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  output reg        rvalid_o,
  // device state and lock
  input  wire [2:0] state_i,
  input  wire       cfg_lock_i,
  input  wire [3:0] group_start_i,
  // asynchronous fault inputs
  input  wire       clk_warn_i,
  input  wire       analog_selftest_fail_i,
  input  wire       enout_err_i,
  input  wire       rstdrv_err_i,
  input  wire [3:0] watchdog_failure_counter_i,
  input  wire [3:0] esm_fail_cnt_i,
  // requests and controls
  output reg        go_safe_o,
  output reg        go_reset_o,
  output reg        wd_fail_flag_o,
  output reg        sched_run_o,
  output reg        auto_selftest_o,
  output reg        spread_spectrum_enable_o,
  output reg        spi_crc_en_o,
  output reg        esm_pwm_mode_o,
  output reg        watchdog_config_bit_o
);

  // --------------------------------------------------------------------
  // state decode and write qualification
  // --------------------------------------------------------------------
  reg  [2:0] state_q;
  wire       in_diag   = (state_i == `SRCFG_ST_DIAG);
  wire       in_active = (state_i == `SRCFG_ST_ACTIVE);
  wire       in_safe   = (state_i == `SRCFG_ST_SAFE);
  wire       in_reset  = (state_i == `SRCFG_ST_RESET);
  wire       diag_act  = in_diag | in_active;
  wire       wr_ok     = wr_i & in_diag & ~cfg_lock_i; // [R16]
  wire       reset_entry = in_reset & (state_q != `SRCFG_ST_RESET);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= `SRCFG_ST_RESET;
    end else begin
      state_q <= state_i;
    end
  end

  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  wire [7:0] fault_cfg;
  wire [7:0] feat_cfg;
  wire [7:0] thr_cfg;

  // masks keep reserved bits at zero
  srcfg_reg8 #(
    .WMASK   (`SRCFG_FAULT_RESP_MASK),
    .RSTVAL  (`SRCFG_FAULT_RESP_RST),
    .RELMASK (8'h00)
  ) u_fault (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .we_i     (wr_ok & (idx_i == `SRCFG_IDX_FAULT_RESP)),
    .reload_i (1'b0),
    .wdata_i  (wdata_i),
    .q_o      (fault_cfg)
  ); // [R19]

  srcfg_reg8 #(
    .WMASK   (`SRCFG_FEATURE_MASK),
    .RSTVAL  (`SRCFG_FEATURE_RST),
    .RELMASK (`SRCFG_FEATURE_RSTMASK)
  ) u_feat (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .we_i     (wr_ok & (idx_i == `SRCFG_IDX_FEATURE)),
    .reload_i (reset_entry),
    .wdata_i  (wdata_i),
    .q_o      (feat_cfg)
  ); // [R15]

  srcfg_reg8 #(
    .WMASK   (8'hff),
    .RSTVAL  (`SRCFG_THRESH_RST),
    .RELMASK (8'h00)
  ) u_thr (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .we_i     (wr_ok & (idx_i == `SRCFG_IDX_THRESH)),
    .reload_i (1'b0),
    .wdata_i  (wdata_i),
    .q_o      (thr_cfg)
  ); // [R17]

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  wire [11:0] flt_s;

  srcfg_sync2 #(
    .W (12)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({esm_fail_cnt_i, watchdog_failure_counter_i, rstdrv_err_i,
              enout_err_i, analog_selftest_fail_i, clk_warn_i}),
    .q_o    (flt_s)
  );

  wire       clk_warn_s = flt_s[0];
  wire       analog_selftest_s    = flt_s[1];
  wire       enout_s    = flt_s[2];
  wire       rstdrv_s   = flt_s[3];
  // counts may tear across bits while moving; a compare glitch lasts a
  // cycle at most, acceptable since counters move slowly
  wire [3:0] wd_cnt_s   = flt_s[7:4];
  wire [3:0] esm_cnt_s  = flt_s[11:8];

  // --------------------------------------------------------------------
  // fault decision
  // --------------------------------------------------------------------
  wire wd_hit  = (wd_cnt_s >= thr_cfg[3:0]);  // [R17]
  wire esm_hit = (esm_cnt_s >= thr_cfg[7:4]); // [R18]
  // masked in safe, stored bit untouched
  wire wd_rst_eff = feat_cfg[`SRCFG_WD_RST_BIT] & ~in_safe; // [R13]
  wire esm_rst_en = feat_cfg[`SRCFG_ESM_RST_BIT];

  reg next_safe;
  reg next_reset;

  always @* begin
    next_safe  = 1'b0;
    next_reset = 1'b0;
    if (diag_act) begin
      if (fault_cfg[`SRCFG_CLK_WARN_BIT] & clk_warn_s)
        next_safe = 1'b1; // [R1]
      if (fault_cfg[`SRCFG_ANALOG_SELFTEST_FAIL_BIT] & analog_selftest_s)
        next_safe = 1'b1; // [R4]
      if (fault_cfg[`SRCFG_ENOUT_ERR_BIT] & enout_s)
        next_safe = 1'b1; // [R5]
      if (fault_cfg[`SRCFG_RSTDRV_SAFE_BIT] & rstdrv_s)
        next_safe = 1'b1; // [R7]
      if (wd_hit & wd_rst_eff)
        next_reset = 1'b1; // [R12]
      if (wd_hit & ~wd_rst_eff)
        next_safe = 1'b1; // [R12]
    end
    if (diag_act | in_safe) begin
      if (fault_cfg[`SRCFG_RSTDRV_RST_BIT] & rstdrv_s)
        next_reset = 1'b1; // [R6]
      if (esm_hit & esm_rst_en)
        next_reset = 1'b1; // [R14]
      if (esm_hit & ~esm_rst_en & diag_act)
        next_safe = 1'b1; // [R18]
    end
    if (next_reset)
      next_safe = 1'b0; // [R8]
  end

  // --------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      go_safe_o       <= 1'b0;
      go_reset_o      <= 1'b0;
      wd_fail_flag_o  <= 1'b0;
      sched_run_o     <= 1'b0;
      auto_selftest_o <= 1'b0;
      spread_spectrum_enable_o        <= 1'b0;
      spi_crc_en_o    <= 1'b0;
      esm_pwm_mode_o  <= 1'b0;
      watchdog_config_bit_o        <= 1'b0;
      rdata_o         <= 8'h00;
      rvalid_o        <= 1'b0;
    end else begin
      go_safe_o  <= next_safe;
      go_reset_o <= next_reset;
      // sticky; cleared by an accepted write of the threshold register, unless a watchdog hit sets it in that cycle
      if (diag_act & wd_hit)
        wd_fail_flag_o <= 1'b1; // [R17]
      else if (wr_ok & (idx_i == `SRCFG_IDX_THRESH))
        wd_fail_flag_o <= 1'b0;
      sched_run_o <= in_active & fault_cfg[`SRCFG_SCHED_EN_BIT]
                     & (|group_start_i); // [R2]
      auto_selftest_o <= reset_entry
                         & ~fault_cfg[`SRCFG_AUTO_DIS_BIT]; // [R3]
      spread_spectrum_enable_o       <= feat_cfg[`SRCFG_SSM_BIT];      // [R9]
      spi_crc_en_o   <= feat_cfg[`SRCFG_CRC_BIT];      // [R10]
      esm_pwm_mode_o <= feat_cfg[`SRCFG_ESM_MODE_BIT]; // [R11]
      watchdog_config_bit_o       <= feat_cfg[`SRCFG_WATCHDOG_CONFIG_BIT_BIT];
      rvalid_o <= rd_i;
      if (rd_i) begin
        case (idx_i)
          `SRCFG_IDX_FAULT_RESP: rdata_o <= fault_cfg;
          `SRCFG_IDX_FEATURE:    rdata_o <= feat_cfg;
          `SRCFG_IDX_THRESH:     rdata_o <= thr_cfg;
          default:               rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ===== sim/srcfg_properties.sv
// checker for the safety response configuration bank
// assumes it is bound onto srcfg_top in the bench
`timescale 1ns/1ps
module srcfg_properties (
  input wire       clk_i, rstn_i, wr_i, rd_i, cfg_lock_i, rvalid_o,
  input wire [1:0] idx_i,
  input wire [2:0] state_i,
  input wire [3:0] group_start_i,
  input wire [7:0] wdata_i, rdata_o,
  input wire       go_safe_o, go_reset_o, sched_run_o, auto_selftest_o,
  input wire       spread_spectrum_enable_o, spi_crc_en_o, esm_pwm_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire legal_wr = wr_i && state_i == 3'h1 && !cfg_lock_i;
  sequence feat_wr;
    legal_wr && idx_i == 2'h1;
  endsequence
  // three cycles in reset so the reload has surely landed
  sequence rst_entry;
    state_i != 3'h0 ##1 (state_i == 3'h0)[*3];
  endsequence
  AST_SSM: assert property (
    feat_wr |-> ##2 spread_spectrum_enable_o == $past(wdata_i[6], 2))
    else $error("spread spectrum enable wrong after write");
  AST_CRC: assert property (
    feat_wr |-> ##2 spi_crc_en_o == $past(wdata_i[4], 2))
    else $error("crc enable wrong after write");
  AST_HOLD: assert property (
    $changed(spread_spectrum_enable_o) |-> $past(legal_wr && idx_i == 2'h1, 2))
    else $error("feature bit changed without a legal write");
  AST_EXCL: assert property (
    !(go_safe_o && go_reset_o))
    else $error("safe and reset requested together");
  AST_RELOAD: assert property (
    rst_entry |=> !esm_pwm_mode_o)
    else $error("monitor mode not reloaded on reset entry");
  AST_AUTOP: assert property (
    auto_selftest_o |=> !auto_selftest_o)
    else $error("auto self-test pulse too long");
  AST_SCHED: assert property (
    sched_run_o |-> $past(state_i == 3'h2 && group_start_i != 4'h0))
    else $error("scheduler runs outside active or with no group");
  AST_RSVD: assert property (
    rd_i && idx_i == 2'h3 |=> rvalid_o && rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ===== sim/srcfg_host.sv
// host model driving the register decoder strobes
// assumes the design samples on the rising edge of clk_i
`timescale 1ns/1ps
module srcfg_host (
  input  wire       clk_i,
  input  wire       rvalid_i,
  input  wire [7:0] rdata_i,
  output reg        wr_o = 1'b0,
  output reg        rd_o = 1'b0,
  output reg  [1:0] idx_o = 2'h3,
  output reg  [7:0] wdata_o = 8'h00
);
  // released lines invert so no stale value looks valid
  task wr(input [1:0] i, input [7:0] d);
    begin
      @(negedge clk_i);
      wr_o = 1'b1;
      idx_o = i;
      wdata_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
      idx_o = ~i;
      wdata_o = ~d;
    end
  endtask
  task rd(input [1:0] i, output [7:0] d);
    begin
      @(negedge clk_i);
      rd_o = 1'b1;
      idx_o = i;
      @(negedge clk_i);
      rd_o = 1'b0;
      idx_o = ~i;
      d = rvalid_i ? rdata_i : 8'hxx;
    end
  endtask
endmodule

// ===== sim/safety_response_config_tb.sv
// bench for the safety response configuration bank
// assumes srcfg_host drives the strobes; model kept in m[]
`timescale 1ns/1ps
module safety_response_config_tb;
  reg        clk_i, rstn_i, cfg_lock_i;
  reg  [2:0] state_i;
  reg  [3:0] group_start_i, flt, wd_cnt, esm_cnt;
  wire       wr, rd, rvalid, go_safe, go_reset, wflag, sched, autop;
  wire       ssm, crc, pwm, wdc;
  wire [1:0] idx;
  wire [7:0] wdata, rdata;
  reg  [7:0] got, npulse;
  reg  [7:0] m [0:3];
  integer    n_errors = 0, n_checks = 0, cyc = 0, seed = 88537, i;
  srcfg_host host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .wr_o(wr), .rd_o(rd), .idx_o(idx), .wdata_o(wdata));
  srcfg_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .wr_i(wr), .rd_i(rd),
    .idx_i(idx), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .state_i(state_i), .cfg_lock_i(cfg_lock_i),
    .group_start_i(group_start_i), .clk_warn_i(flt[3]),
    .analog_selftest_fail_i(flt[2]), .enout_err_i(flt[1]), .rstdrv_err_i(flt[0]),
    .watchdog_failure_counter_i(wd_cnt), .esm_fail_cnt_i(esm_cnt),
    .go_safe_o(go_safe), .go_reset_o(go_reset), .wd_fail_flag_o(wflag),
    .sched_run_o(sched), .auto_selftest_o(autop), .spread_spectrum_enable_o(ssm),
    .spi_crc_en_o(crc), .esm_pwm_mode_o(pwm), .watchdog_config_bit_o(wdc));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (autop === 1'b1) npulse = npulse + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // model takes a write only where the design may accept it
  task mwr(input [1:0] a, input [7:0] d);
    begin
      host.wr(a, d);
      if (state_i == 3'h1 && !cfg_lock_i)
        m[a] = d & (a == 2'h0 ? 8'hbf : a == 2'h1 ? 8'h5f : 8'hff);
    end
  endtask
  task rdchk(input [1:0] a);
    begin
      host.rd(a, got);
      chk(got, m[a]);
    end
  endtask
  // reset request wins; safe state masks the watchdog response
  function [1:0] resp(input [2:0] s);
    reg rs, sf, wdh, esh, on;
    begin
      on = s == 3'h1 || s == 3'h2;
      wdh = wd_cnt >= m[2][3:0];
      esh = esm_cnt >= m[2][7:4];
      rs = flt[0] & m[0][1] | wdh & on & m[1][1] | esh & m[1][0];
      sf = on & (flt[3] & m[0][7] | flt[2] & m[0][3] | flt[1] & m[0][2]
        | flt[0] & m[0][0] | wdh & !m[1][1] | esh & !m[1][0]);
      resp = {rs, sf & !rs};
    end
  endfunction
  initial begin
    {rstn_i, cfg_lock_i, state_i, group_start_i} = 0;
    {flt, wd_cnt, esm_cnt, npulse} = 0;
    m[0] = 8'h00; m[1] = 8'h02; m[2] = 8'hff; m[3] = 8'h00;
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    for (i = 0; i < 4; i = i + 1) rdchk(i);
    for (i = 0; i < 30; i = i + 1) begin
      {flt, wd_cnt, esm_cnt} = 0;
      cfg_lock_i = ($random(seed) & 3) == 0;
      state_i = ($random(seed) & 3) == 0 ? 3'h2 : 3'h1;
      mwr(0, $random(seed));
      mwr(1, $random(seed));
      mwr(2, $random(seed));
      state_i = {$random(seed)} % 3 + 1;
      {flt, wd_cnt, esm_cnt, group_start_i} = $random(seed);
      repeat (4) @(negedge clk_i);
      chk({go_reset, go_safe}, resp(state_i));
      chk(sched, state_i == 2 && m[0][5] && group_start_i != 0);
      chk({ssm, crc, pwm, wdc}, {m[1][6], m[1][4], m[1][2], m[1][3]});
      if (state_i != 3'h3) chk(wflag, wd_cnt >= m[2][3:0]);
      rdchk(i[1:0]);
    end
    for (i = 0; i < 2; i = i + 1) begin
      {flt, wd_cnt, esm_cnt, cfg_lock_i} = 0;
      state_i = 3'h1;
      mwr(0, i << 4);
      mwr(1, 8'h5d);
      npulse = 0;
      state_i = 3'h0;
      repeat (4) @(negedge clk_i);
      chk(npulse, !m[0][4]);
      m[1] = (m[1] & 8'hf8) | 8'h02;
      rdchk(1);
    end
    give_verdict;
  end
endmodule
bind srcfg_top srcfg_properties chk (.*);
